// >>> pkg/ssq_pkg.sv
// Shared constants for the sense switch sequencer.
// Assumes a 250 MHz core clock and a 32-bit AXI4-Lite register bus.
package ssq_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CAL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [31:0] CTRL_RST = 32'h000a_0000;
  localparam logic [2:0] CAL_PWRUP = 3'h7;
  // Control fields
  localparam int F_BEMF = 0;
  localparam int F_RDSON = 1;
  localparam int F_CS_SH = 2;
  localparam int F_BEMF_SH = 3;
  localparam int F_SINGLE = 4;
  localparam int F_EXT_CT = 5;
  localparam int F_GAIN = 6;
  localparam int F_CONN = 8;
  localparam int F_GT = 16;
  // Status fields
  localparam int S_CAL = 0;
  localparam int S_SAMPLE = 3;
  localparam int S_HV = 6;
  localparam int S_PHASE = 9;
  localparam int S_MUX = 12;
  // ----------------------------------------------------------------
  // Gain codes: 5, 10, 20, 40 V/V
  // ----------------------------------------------------------------
  localparam logic [1:0] GAIN_5 = 2'h0;
  localparam logic [1:0] GAIN_10 = 2'h1;
  localparam logic [1:0] GAIN_20 = 2'h2;
  localparam logic [1:0] GAIN_40 = 2'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PS = 4000;
  localparam int PROP_NS = 40;
  localparam int PROP_CYC = (PROP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CAL_ALL_US = 768;
  localparam int CAL_AMP_CYC = CAL_ALL_US * 1000000 / CLK_PS / 3;
  localparam int CNT_W = 20;
  localparam int DLY_W = 9;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } ssq_cal_state_t;
endpackage : ssq_pkg

// >>> logic/ssq_delay.sv
// Start-delay-stop timer driving one timed switch.
// Assumes start and stop are one-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module ssq_delay (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [ssq_pkg::DLY_W-1:0] i_delay,
  output logic o_ready
);
  logic [ssq_pkg::DLY_W-1:0] cnt;
  logic armed;
  wire done = armed && (cnt >= i_delay);

  // Restart on every start, stop wins only when no start
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt <= '0;
      armed <= 1'b0;
      o_ready <= 1'b0;
    end else if (i_clk_en) begin
      if (i_start) begin
        cnt <= '0;
        armed <= 1'b1;
        o_ready <= 1'b0;
      end else if (i_stop) begin
        armed <= 1'b0;
        o_ready <= 1'b0;
      end else if (done) begin
        o_ready <= 1'b1;
      end else if (armed) begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule : ssq_delay
`default_nettype wire

// >>> logic/ssq_calib.sv
// Offset calibration sequencer for three amplifiers, one at a time.
// Assumes requests are one-cycle pulses; pending set wins over clear.
`timescale 1ns/1ps
`default_nettype none
module ssq_calib #(
  parameter int STEP_CYC = ssq_pkg::CAL_AMP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [2:0] i_req,
  output logic [2:0] o_pending,
  output logic [2:0] o_active
);
  ssq_pkg::ssq_cal_state_t state;
  logic [ssq_pkg::CNT_W-1:0] cnt;
  wire last = (cnt == ssq_pkg::CNT_W'(STEP_CYC - 1));
  wire [2:0] done = (state == ssq_pkg::CAL_RUN && last) ? o_active : 3'h0;
  // Lowest pending channel goes first
  wire [2:0] pick = o_pending & (~o_pending + 3'h1);
  wire [2:0] next_pending = (o_pending & ~done) | i_req;

  // Pending starts full so power-up calibrates all three
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= ssq_pkg::CAL_IDLE;
      cnt <= '0;
      o_active <= 3'h0;
      o_pending <= ssq_pkg::CAL_PWRUP;
    end else if (i_clk_en) begin
      o_pending <= next_pending;
      unique case (state)
        ssq_pkg::CAL_IDLE: begin
          cnt <= '0;
          if (|o_pending) begin
            o_active <= pick;
            state <= ssq_pkg::CAL_RUN;
          end
        end
        ssq_pkg::CAL_RUN: begin
          cnt <= cnt + 1'b1;
          if (last) begin
            o_active <= 3'h0;
            state <= ssq_pkg::CAL_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ssq_calib
`default_nettype wire

// >>> logic/ssq_top.sv
// Switch sequencer for the three current-sense and back-EMF chains.
// Assumes gate inputs and select pins are asynchronous pins, gate-off and
// low-side-on commands come from driver logic on the same clock.
//
// How it works
// - Three-shunt S/H routes held channel picked by output select to buffer.
// - Three-shunt S/H drives all sampling switches from internal timing.
// - Rdson sensing closes input switches B, A, C while that low side on.
// - Single-shunt with back-EMF keeps phase B overcurrent detection on.
// - Back-EMF closes external or internal center switch per setting.
// - Phase pick pins decode to none, A, B, C.
// - With S/H, output pick pins decode to none, A, B, C.
// - HV sense switch closes after low-side-on plus transition, opens on gate-off.
// - Back-EMF holds the chain link switch closed.
// - Back-EMF uses the third amplifier as final chain stage.
// - Four gains: 5, 10, 20, 40 V/V.
// - Power-up calibrates all three amplifiers automatically.
// - Each set request bit calibrates its amplifier; several allowed.
// - Calibration opens inputs, shorts them, forces 40 V/V, auto-zeros.
// - All three calibrations finish in about 768 us.
// - Connection bit picks internal short or shunt during calibration.
// - Amplifier inputs monitored for overcurrent regardless of sampling.
// - Sample only with a high side on and exactly one low side on.
// - Sample closes propagation delay plus transition after a rising edge.
// - Sample opens on gate-off falling edge, entering hold.
// - Floating phase node sensed for back-EMF, low-side shunt for current.
`timescale 1ns/1ps
`default_nettype none
module ssq_top #(
  parameter int CAL_AMP_CYC = ssq_pkg::CAL_AMP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // AXI4-Lite
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Pins from the controller
  input wire logic i_phase_pick_in1,
  input wire logic i_phase_pick_in2,
  input wire logic i_out_pick_in1,
  input wire logic i_out_pick_in2,
  input wire logic [2:0] i_high_side_input,
  input wire logic [2:0] i_low_side_input,
  // Driver logic, same clock
  input wire logic [2:0] i_gate_off,
  input wire logic [2:0] i_low_side_on_cmd,
  input wire logic [2:0] i_ls_gate_off,
  // Switch controls
  output logic o_phase_a_switch,
  output logic o_phase_b_switch,
  output logic o_phase_c_switch,
  output logic [2:0] o_mux_switch,
  output logic [2:0] o_sample_switch,
  output logic [2:0] o_rdson_in_switch,
  output logic [2:0] o_hv_sense_switch,
  output logic o_chain_link_switch,
  output logic o_third_amp_bemf,
  output logic o_ext_center_switch,
  output logic o_virt_center_switch,
  output logic [5:0] o_gain,
  output logic [2:0] o_input_open,
  output logic [2:0] o_input_short,
  output logic [2:0] o_autozero,
  output logic [2:0] o_ocp_monitor_en,
  output logic [2:0] o_bemf_phase,
  output logic [2:0] o_shunt_phase
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [9:0] pin_s1;
  logic [9:0] pin_s2;
  logic [2:0] hi_d;
  logic [2:0] lo_d;
  logic [2:0] goff_d;
  logic [2:0] lson_d;
  wire [9:0] pin_raw = {i_out_pick_in1, i_out_pick_in2, i_phase_pick_in1,
                        i_phase_pick_in2, i_high_side_input, i_low_side_input};
  wire [2:0] hi = pin_s2[5:3];
  wire [2:0] lo = pin_s2[2:0];
  wire [1:0] ph_pick = pin_s2[7:6];
  wire [1:0] out_pick = pin_s2[9:8];

  // Two stages, then one delay stage for edge detection
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      hi_d <= '0;
      lo_d <= '0;
      goff_d <= '0;
      lson_d <= '0;
    end else if (i_clk_en) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      hi_d <= hi;
      lo_d <= lo;
      goff_d <= i_gate_off;
      lson_d <= i_low_side_on_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [2:0] cal_req;
  wire [2:0] cal_pending;
  wire [2:0] cal_active;
  wire bemf_en = ctrl[ssq_pkg::F_BEMF];
  wire rdson = ctrl[ssq_pkg::F_RDSON];
  wire cs_sh = ctrl[ssq_pkg::F_CS_SH];
  wire bemf_sh = ctrl[ssq_pkg::F_BEMF_SH];
  wire single = ctrl[ssq_pkg::F_SINGLE];
  wire ext_ct = ctrl[ssq_pkg::F_EXT_CT];
  wire [1:0] gain = ctrl[ssq_pkg::F_GAIN +: 2];
  wire conn_shunt = ctrl[ssq_pkg::F_CONN];
  wire [7:0] gt = ctrl[ssq_pkg::F_GT +: 8];
  wire do_wr = aw_held && w_held && !o_bvalid;
  wire wr_ctrl = do_wr && aw_addr == ssq_pkg::OFS_CTRL;
  wire wr_cal = do_wr && aw_addr == ssq_pkg::OFS_CAL;
  wire wr_ok = wr_ctrl || wr_cal || aw_addr == ssq_pkg::OFS_STAT;
  wire rd_ctrl = i_araddr == ssq_pkg::OFS_CTRL;
  wire rd_cal = i_araddr == ssq_pkg::OFS_CAL;
  wire rd_stat = i_araddr == ssq_pkg::OFS_STAT;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] stat = {17'h0, o_mux_switch,
                      o_phase_c_switch, o_phase_b_switch, o_phase_a_switch,
                      o_hv_sense_switch, o_sample_switch, cal_active};
  wire [31:0] rd_val = rd_ctrl ? ctrl :
                       rd_cal ? {29'h0, cal_pending} :
                       rd_stat ? stat : 32'h0;
  assign o_awready = !aw_held;
  assign o_wready = !w_held;
  assign o_arready = !o_rvalid;

  // Write channel: address and data taken in either order
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      o_bvalid <= 1'b0;
      o_bresp <= ssq_pkg::RESP_OK;
      ctrl <= ssq_pkg::CTRL_RST;
      cal_req <= '0;
    end else if (i_clk_en) begin
      cal_req <= '0;
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_ok ? ssq_pkg::RESP_OK : ssq_pkg::RESP_ERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= (ctrl & ~wmask) | (w_data & wmask);
      end
      if (wr_cal && w_strb[0]) begin
        cal_req <= w_data[2:0];
      end
    end
  end

  // Read channel: answer one cycle after address taken
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= ssq_pkg::RESP_OK;
    end else if (i_clk_en) begin
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_val;
        o_rresp <= (rd_ctrl || rd_cal || rd_stat) ? ssq_pkg::RESP_OK : ssq_pkg::RESP_ERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration
  // ----------------------------------------------------------------
  // Pending bits, serial run
  ssq_calib #(
    .STEP_CYC(CAL_AMP_CYC)
  ) u_calib (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_req(cal_req),
    .o_pending(cal_pending),
    .o_active(cal_active)
  );

  // ----------------------------------------------------------------
  // Sample/hold and on-resistance timing
  // ----------------------------------------------------------------
  wire [2:0] goff_fall = goff_d & ~i_gate_off;
  wire in_rise = |((hi & ~hi_d) | (lo & ~lo_d));
  localparam int DLY_T = ssq_pkg::DLY_W;
  wire [DLY_T-1:0] sh_dly = DLY_T'(ssq_pkg::PROP_CYC) + DLY_T'(gt);
  // Some high side, exactly one low side
  wire sh_window = (|hi) && $onehot(lo);
  wire sh_timed;
  wire [2:0] hv_timed;

  // Restart on input rise, hold on gate-off fall
  ssq_delay u_sh_dly (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_start(in_rise),
    .i_stop(|goff_fall),
    .i_delay(sh_dly),
    .o_ready(sh_timed)
  );

  for (genvar p = 0; p < 3; p++) begin : g_hv
    ssq_delay u_hv_dly (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_start(i_low_side_on_cmd[p] && !lson_d[p]),
      .i_stop(i_ls_gate_off[p]),
      .i_delay(DLY_T'(gt)),
      .o_ready(hv_timed[p])
    );
  end

  // ----------------------------------------------------------------
  // Switch selection
  // ----------------------------------------------------------------
  // Pick pins to one-hot phase
  wire [2:0] ph_dec = (ph_pick == 2'h1) ? 3'h1 :
                      (ph_pick == 2'h2) ? 3'h2 :
                      (ph_pick == 2'h3) ? 3'h4 : 3'h0;
  // Output pick to channel, third routes third amp
  wire [2:0] out_dec = (out_pick == 2'h1) ? 3'h1 :
                       (out_pick == 2'h2) ? 3'h2 :
                       (out_pick == 2'h3) ? 3'h4 : 3'h0;
  wire sh_any = cs_sh || (bemf_en && bemf_sh);
  wire sample_now = sh_window && sh_timed && !in_rise; // Stale ready must not sample a new edge
  // Shunt S/H channels from internal timing only
  wire [2:0] cs_sh_mask = !cs_sh || rdson ? 3'h0 :
                          !bemf_en ? 3'h7 :
                          single ? 3'h1 : 3'h3;
  wire [2:0] sh_mask = cs_sh_mask | {bemf_en && bemf_sh, 2'h0};
  // Input switch order is B, A, C
  wire [2:0] ls_bac = {lo[2], lo[0], lo[1]};
  wire [2:0] rd_mask = bemf_en ? 3'h3 : 3'h7;
  wire [2:0] gain40 = cal_active;
  // Overcurrent watch, third lost to back-EMF
  wire [2:0] ocp = {!bemf_en, 2'h3};
  wire [5:0] gain_all;

  // Calibrating channel forced to 40 V/V
  for (genvar c = 0; c < 3; c++) begin : g_gain
    assign gain_all[2*c +: 2] = gain40[c] ? ssq_pkg::GAIN_40 : gain;
  end

  // Switch outputs registered so no glitch reaches analog
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      {o_phase_c_switch, o_phase_b_switch, o_phase_a_switch} <= '0;
      o_mux_switch <= '0;
      o_sample_switch <= '0;
      o_rdson_in_switch <= '0;
      o_hv_sense_switch <= '0;
      o_chain_link_switch <= 1'b0;
      o_third_amp_bemf <= 1'b0;
      o_ext_center_switch <= 1'b0;
      o_virt_center_switch <= 1'b0;
      o_gain <= '0;
      o_input_open <= '0;
      o_input_short <= '0;
      o_autozero <= '0;
      o_ocp_monitor_en <= '0;
      o_bemf_phase <= '0;
      o_shunt_phase <= '0;
    end else if (i_clk_en) begin
      {o_phase_c_switch, o_phase_b_switch, o_phase_a_switch} <= bemf_en ? ph_dec : 3'h0;
      o_mux_switch <= sh_any ? out_dec : 3'h0;
      o_sample_switch <= sample_now ? sh_mask : 3'h0;
      o_rdson_in_switch <= rdson ? (ls_bac & rd_mask) : 3'h0;
      o_hv_sense_switch <= rdson ? (hv_timed & rd_mask) : 3'h0;
      o_chain_link_switch <= bemf_en;
      o_third_amp_bemf <= bemf_en;
      o_ext_center_switch <= bemf_en && ext_ct;
      o_virt_center_switch <= bemf_en && !ext_ct;
      o_gain <= gain_all;
      // Open and short inputs unless shunt kept
      o_input_open <= conn_shunt ? 3'h0 : cal_active;
      o_input_short <= conn_shunt ? 3'h0 : cal_active;
      o_autozero <= cal_active;
      o_ocp_monitor_en <= ocp;
      o_bemf_phase <= ~(hi | lo);
      o_shunt_phase <= lo;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  chk_phase_decode: assert property (
    i_clk_en && bemf_en && ph_pick == 2'h2 |=> o_phase_b_switch && !o_phase_a_switch)
    else $error("phase pick decode wrong");
  chk_mux_decode: assert property (
    i_clk_en && sh_any && out_pick == 2'h3 |=> o_mux_switch == 3'h4)
    else $error("output pick decode wrong");
  chk_center_sel: assert property (
    i_clk_en |=> o_ext_center_switch == $past(bemf_en && ext_ct)
      && o_virt_center_switch == $past(bemf_en && !ext_ct))
    else $error("center switch wrong");
  chk_sample_window: assert property (
    |o_sample_switch |-> $past(sh_window))
    else $error("sample outside window");
  chk_sample_delay: assert property (
    i_clk_en && in_rise ##1 i_clk_en [*8] |-> o_sample_switch == 3'h0)
    else $error("sample closed too early");
  chk_sample_restart: assert property (
    i_clk_en && in_rise |=> o_sample_switch == 3'h0)
    else $error("sample closed on input edge");
  chk_hold_open: assert property (
    i_clk_en && |goff_fall ##1 i_clk_en |=> o_sample_switch == 3'h0)
    else $error("sample not opened");
  chk_cal_gain: assert property (
    i_clk_en && cal_active[1] |=> o_gain[3:2] == ssq_pkg::GAIN_40 && o_autozero[1])
    else $error("calibration gain not forced");
  chk_powerup_cal: assert property (
    $rose(i_rst_n) |-> cal_pending == 3'h7)
    else $error("power-up calibration missing");
  chk_req_clear: assert property (
    $fell(cal_active[0]) && !$past(cal_req[0]) |-> !cal_pending[0])
    else $error("request bit not cleared");
  chk_ocp_b: assert property (
    i_clk_en ##1 i_clk_en |-> o_ocp_monitor_en[1])
    else $error("phase b overcurrent off");
  chk_link_bemf: assert property (
    i_clk_en && bemf_en |=> o_chain_link_switch && o_third_amp_bemf)
    else $error("chain link open");

  cov_sample: cover property (|o_sample_switch);
  cov_cal_done: cover property ($fell(cal_active[2]));
  cov_hv: cover property (|o_hv_sense_switch);
endmodule : ssq_top
`default_nettype wire

// >>> sim/ssq_mcu_model.sv
// Controller model driving the select pins and gate inputs.
// Assumes bench commands change only just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ssq_mcu_model (
  input wire logic i_mclk,
  input wire logic [1:0] i_phase,
  input wire logic [1:0] i_out,
  input wire logic [2:0] i_hi,
  input wire logic [2:0] i_lo,
  output logic o_ph1,
  output logic o_ph2,
  output logic o_out1,
  output logic o_out2,
  output logic [2:0] o_hi,
  output logic [2:0] o_lo
);
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // pins, in1 high bit
  always @(posedge i_mclk) begin
    {o_ph1, o_ph2} <= i_phase;
    {o_out1, o_out2} <= i_out;
    o_hi <= i_hi;
    o_lo <= i_lo;
  end
endmodule : ssq_mcu_model
`default_nettype wire

// >>> sim/test_sense_switch_sequencer.sv
// Bench for the sense switch sequencer: bus, pins, timing, calibration.
// Assumes a short calibration step so runs stay brief.
`timescale 1ns/1ps
`default_nettype none
module test_sense_switch_sequencer;
  typedef struct packed {logic [1:0] pin; logic [2:0] sel; logic [2:0] lo; logic [2:0] rd;} ssq_row_t;
  logic i_mclk, i_rst_n, i_clk_en, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, c0, d;
  logic [3:0] i_wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, r, ph_cmd, out_cmd;
  logic i_phase_pick_in1, i_phase_pick_in2, i_out_pick_in1, i_out_pick_in2;
  logic [2:0] i_high_side_input, i_low_side_input, i_gate_off, i_low_side_on_cmd, i_ls_gate_off;
  logic [2:0] hi_cmd, lo_cmd, o_mux_switch, o_sample_switch, o_rdson_in_switch, o_hv_sense_switch;
  logic [2:0] o_input_open, o_input_short, o_autozero, o_ocp_monitor_en, o_bemf_phase, o_shunt_phase;
  logic o_phase_a_switch, o_phase_b_switch, o_phase_c_switch, o_chain_link_switch;
  logic o_third_amp_bemf, o_ext_center_switch, o_virt_center_switch;
  logic [5:0] o_gain;
  int failures, comparisons;
  ssq_row_t rows [4] = '{'{2'h0, 3'h0, 3'h0, 3'h0}, '{2'h1, 3'h1, 3'h1, 3'h2},
                         '{2'h2, 3'h2, 3'h2, 3'h1}, '{2'h3, 3'h4, 3'h4, 3'h4}};
  logic [1:0] gains [4] = '{ssq_pkg::GAIN_5, ssq_pkg::GAIN_10, ssq_pkg::GAIN_20, ssq_pkg::GAIN_40};

  // Short calibration step keeps the run small
  ssq_top #(.CAL_AMP_CYC(20)) DUT (.*);
  ssq_mcu_model mcu (.i_mclk(i_mclk), .i_phase(ph_cmd), .i_out(out_cmd), .i_hi(hi_cmd),
    .i_lo(lo_cmd), .o_ph1(i_phase_pick_in1), .o_ph2(i_phase_pick_in2), .o_out1(i_out_pick_in1),
    .o_out2(i_out_pick_in2), .o_hi(i_high_side_input), .o_lo(i_low_side_input));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : tick
  // Starts on an edge so a released strobe is never raised twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge i_mclk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= v;
    i_bready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    i_bready <= 1'b0;
    chk("bresp", o_bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    i_rready <= 1'b0;
    d = o_rdata;
    r = o_rresp;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    rd(a);
    chk("rdata", d, v);
    chk("rresp", r, er);
  endtask : rchk
  // Polls until every pending calibration bit has cleared itself
  task automatic calw();
    do rd(ssq_pkg::OFS_CAL);
    while (d[2:0] !== 3'h0);
  endtask : calw
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // Whole sequence needs well under 5000 cycles
  initial begin
    #40000;
    failures++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata} = '0;
    {ph_cmd, out_cmd, hi_cmd, lo_cmd, i_gate_off, i_low_side_on_cmd, i_ls_gate_off} = '0;
    {i_clk_en, i_wstrb, i_rst_n} = 6'h3e;
    c0 = ssq_pkg::CTRL_RST;
    tick(8);
    chk("rst sample", o_sample_switch, 3'h0);
    chk("rst awready", o_awready, 1'b1);
    i_rst_n <= 1'b1;
    tick(3);
    rchk(ssq_pkg::OFS_CAL, 32'h7, ssq_pkg::RESP_OK);
    chk("cal gain", o_gain[1:0], ssq_pkg::GAIN_40);
    chk("cal short", o_input_short[0], 1'b1);
    chk("cal open", o_input_open[0], 1'b1);
    rchk(ssq_pkg::OFS_CTRL, c0, ssq_pkg::RESP_OK);
    calw();
    chk("short off", o_input_short, 3'h0);
    for (int g = 0; g < 4; g++) begin
      wr(ssq_pkg::OFS_CTRL, c0 | (g << 6), ssq_pkg::RESP_OK);
      tick(2);
      chk("gain", o_gain, {3{gains[g]}});
    end
    wr(ssq_pkg::OFS_CTRL, c0, ssq_pkg::RESP_OK);
    wr(ssq_pkg::OFS_CAL, 32'h5, ssq_pkg::RESP_OK);
    rchk(ssq_pkg::OFS_CAL, 32'h5, ssq_pkg::RESP_OK);
    chk("req gain", o_gain[1:0], ssq_pkg::GAIN_40);
    chk("skip amp", o_input_short[1], 1'b0);
    calw();
    wr(ssq_pkg::OFS_CTRL, c0 | 32'h100, ssq_pkg::RESP_OK);
    wr(ssq_pkg::OFS_CAL, 32'h1, ssq_pkg::RESP_OK);
    tick(3);
    chk("conn short", o_input_short[0], 1'b0);
    chk("cal zero", o_autozero, 3'h1);
    calw();
    chk("ocp all", o_ocp_monitor_en, 3'h7);
    wr(ssq_pkg::OFS_CTRL, c0 | 32'h11, ssq_pkg::RESP_OK);
    tick(2);
    chk("ocp b", o_ocp_monitor_en[1], 1'b1);
    wr(ssq_pkg::OFS_CTRL, c0 | 32'h0d, ssq_pkg::RESP_OK);
    for (int i = 0; i < 4; i++) begin
      ph_cmd <= rows[i].pin;
      out_cmd <= rows[i].pin;
      tick(5);
      chk("phase", {o_phase_c_switch, o_phase_b_switch, o_phase_a_switch}, rows[i].sel);
      chk("mux", o_mux_switch, rows[i].sel);
    end
    chk("link", {o_chain_link_switch, o_third_amp_bemf}, 2'h3);
    chk("virt", {o_ext_center_switch, o_virt_center_switch}, 2'h1);
    wr(ssq_pkg::OFS_CTRL, c0 | 32'h21, ssq_pkg::RESP_OK);
    tick(2);
    chk("ext", {o_ext_center_switch, o_virt_center_switch}, 2'h2);
    wr(ssq_pkg::OFS_CTRL, c0 | 32'h2, ssq_pkg::RESP_OK);
    for (int i = 0; i < 4; i++) begin
      lo_cmd <= rows[i].lo;
      tick(5);
      chk("rdson", o_rdson_in_switch, rows[i].rd);
    end
    wr(ssq_pkg::OFS_CTRL, c0 | 32'h3, ssq_pkg::RESP_OK);
    tick(2);
    chk("rdson bemf", o_rdson_in_switch, 3'h0);
    lo_cmd <= 3'h0;
    i_low_side_on_cmd <= 3'h1;
    tick(10);
    chk("hv early", o_hv_sense_switch, 3'h0);
    tick(4);
    chk("hv on", o_hv_sense_switch, 3'h1);
    i_ls_gate_off <= 3'h1;
    tick(3);
    chk("hv off", o_hv_sense_switch, 3'h0);
    {i_ls_gate_off, i_low_side_on_cmd} <= 6'h0;
    wr(ssq_pkg::OFS_CTRL, c0 | 32'h4, ssq_pkg::RESP_OK);
    hi_cmd <= 3'h4;
    lo_cmd <= 3'h3;
    tick(40);
    chk("two lows", o_sample_switch, 3'h0);
    {hi_cmd, lo_cmd} <= 6'h0;
    tick(5);
    hi_cmd <= 3'h4;
    lo_cmd <= 3'h1;
    tick(15);
    chk("sample early", o_sample_switch, 3'h0);
    chk("bemf node", o_bemf_phase, 3'h2);
    chk("shunt node", o_shunt_phase, 3'h1);
    tick(15);
    chk("sample on", o_sample_switch, 3'h7);
    i_gate_off <= 3'h4;
    tick(2);
    i_gate_off <= 3'h0;
    tick(3);
    chk("hold", o_sample_switch, 3'h0);
    wr(8'h0c, 32'h1, ssq_pkg::RESP_ERR);
    rchk(8'h0c, 32'h0, ssq_pkg::RESP_ERR);
    test_done();
  end
endmodule : test_sense_switch_sequencer
`default_nettype wire
